// File: src/usb_rx_ep_pkg.sv
// Constants, register map and link event carrier for the receive endpoint
// Assumes one clock, synchronous active-low reset, 16-bit register port
package usb_rx_ep_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register port geometry and offsets
   localparam int          ADDR_W         = 3;
   localparam int          DATA_W         = 16;
   localparam logic [2:0]  OFF_MAXP       = 3'h0;
   localparam logic [2:0]  OFF_CSR        = 3'h1;
   localparam logic [2:0]  OFF_COUNT      = 3'h2;
   localparam logic [2:0]  OFF_TX_TYPE    = 3'h3;
   localparam logic [2:0]  OFF_TX_INTV    = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // Field widths and reset values
   localparam int          MAXP_W         = 11;
   localparam int          COUNT_W        = 13;
   localparam int          FRAMES_W       = 16;
   localparam logic [10:0] MAXP_RESET     = 11'h000;
   localparam logic [12:0] COUNT_RESET    = 13'h0000;
   localparam logic [5:0]  TX_TYPE_RESET  = 6'h00;
   localparam logic [7:0]  TX_INTV_RESET  = 8'h00;
   localparam int          TX_EP_LSB      = 0;
   localparam int          TX_EP_W        = 4;
   localparam int          TX_PROTO_LSB   = 4;

   ////////////////////////////////////////////////////////////////////////
   // Control and status bit positions
   localparam int          CSR_READY      = 0;
   localparam int          CSR_FULL       = 1;
   localparam int          CSR_OVR_ERR    = 2;
   localparam int          CSR_DERR_NAK   = 3;
   localparam int          CSR_FLUSH      = 4;
   localparam int          CSR_STALL_CTL  = 5;
   localparam int          CSR_STALL_EVT  = 6;
   localparam int          CSR_CLR_TOG    = 7;
   localparam int          CSR_ISO_AREQ   = 14;
   localparam int          CSR_AUTO_CLR   = 15;

   ////////////////////////////////////////////////////////////////////////
   // Protocol codes and timing counts
   localparam logic [1:0]  PROTO_RSVD     = 2'h0;
   localparam logic [1:0]  PROTO_ISO      = 2'h1;
   localparam logic [1:0]  PROTO_BULK     = 2'h2;
   localparam logic [1:0]  PROTO_INTR     = 2'h3;
   localparam logic [1:0]  ERR_ATTEMPTS   = 2'h3;
   localparam logic [7:0]  ISO_N_MAX      = 8'h10;
   localparam logic [7:0]  BULK_N_MIN     = 8'h02;
   localparam logic [7:0]  N_ONE          = 8'h01;

   ////////////////////////////////////////////////////////////////////////
   // Events from the packet engine, each flag a one-cycle pulse; pkt_bytes is a byte count
   typedef struct packed {
      logic        pkt_done;
      logic [12:0] pkt_bytes;
      logic        pkt_bad;
      logic        out_token;
      logic        attempt_failed;
      logic        nak;
      logic        stall_in;
      logic        frame_tick;
      logic        toggle_flip;
   } link_event_type;

endpackage : usb_rx_ep_pkg

// File: src/usb_rx_endpoint_control.sv
// Receive endpoint control/status for a dual-role USB controller,
// plus host-mode transmit type and interval settings.
// Assumes a packet engine delivering one-cycle event pulses and a
// data port that pulses unload_byte per byte taken by software.
//
// Overview of operation
// - Eleven-bit maximum payload, zero after reset
// - Half-size payload allows two buffered packets
// - Packet arrival sets ready, optional interrupt
// - Full reads one when no room remains
// - Peripheral isochronous drop sets sticky overrun
// - Isochronous bad packet sets data error
// - Flush drops front packet, only when ready
// - Send-stall answers STALL, not isochronous
// - Each STALL sent sets sticky flag
// - Clear-toggle write zeroes data toggle
// - Peripheral iso bit selects transfer handling
// - Auto-clear pops full-size packet after unload
// - Three failed host bulk/interrupt attempts set error
// - Host bulk NAK limit halts endpoint
// - Request bit launches IN, clears on ready
// - Host STALL received sets sticky flag
// - Auto-request re-arms request when ready clears
// - Thirteen-bit byte count tracks buffer contents
// - Transmit target endpoint and protocol code
// - Interval value decoded per transfer type
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module usb_rx_endpoint_control #(
   parameter int BUF_BYTES = 64
) (
   // Clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 rstn,
   // Register port
   input  wire logic [usb_rx_ep_pkg::ADDR_W-1:0]     reg_addr,
   input  wire logic [usb_rx_ep_pkg::DATA_W-1:0]     reg_wdata,
   input  wire logic                                 reg_write,
   input  wire logic                                 reg_read,
   output logic      [usb_rx_ep_pkg::DATA_W-1:0]     reg_rdata,
   // Mode and receive settings from the controller
   input  wire logic                                 host_mode,
   input  wire logic [1:0]                           rx_protocol,
   input  wire logic [7:0]                           rx_nak_limit,
   input  wire logic                                 irq_enable,
   // Packet engine and data port
   input  wire usb_rx_ep_pkg::link_event_type        link_event,
   input  wire logic                                 unload_byte,
   // Endpoint state
   output logic                                      packet_ready,
   output logic                                      buffer_full,
   output logic                                      in_request,
   output logic                                      endpoint_halted,
   output logic                                      stall_handshake,
   output logic                                      data_toggle,
   output logic                                      endpoint_irq,
   // Transmit endpoint settings
   output logic      [3:0]                           tx_target_endpoint,
   output logic      [1:0]                           tx_protocol,
   output logic      [usb_rx_ep_pkg::FRAMES_W-1:0]   tx_interval_frames
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check
   if (BUF_BYTES < 1 || BUF_BYTES > 4096) begin : g_bad_buf
      $error("BUF_BYTES must lie in 1..4096");
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame count for an interval value, zero meaning disabled
   function automatic logic [usb_rx_ep_pkg::FRAMES_W-1:0] interval_frames(
      input logic [1:0] proto,
      input logic [7:0] n
   );
      logic [usb_rx_ep_pkg::FRAMES_W-1:0] f;
      f = '0;
      case (proto)
         usb_rx_ep_pkg::PROTO_INTR: begin
            f = {8'h00, n};
         end
         usb_rx_ep_pkg::PROTO_ISO: begin
            if (n >= usb_rx_ep_pkg::N_ONE && n <= usb_rx_ep_pkg::ISO_N_MAX)
               f = 16'h0001 << (n - usb_rx_ep_pkg::N_ONE);
         end
         usb_rx_ep_pkg::PROTO_BULK: begin
            if (n >= usb_rx_ep_pkg::BULK_N_MIN && n <= usb_rx_ep_pkg::ISO_N_MAX)
               f = 16'h0001 << (n - usb_rx_ep_pkg::N_ONE);
         end
         default: begin
            f = '0;
         end
      endcase
      return f;
   endfunction : interval_frames

   ////////////////////////////////////////////////////////////////////////
   // State
   localparam int CW = usb_rx_ep_pkg::COUNT_W;

   logic [usb_rx_ep_pkg::MAXP_W-1:0]   max_payload_bytes;
   logic [1:0]                         pkt_count;
   logic [CW-1:0]                      front_size;
   logic [CW-1:0]                      front_left;
   logic                               front_err;
   logic [CW-1:0]                      back_size;
   logic                               back_err;
   logic [CW-1:0]                      byte_count;
   logic                               auto_clear_mode;
   logic                               iso_or_auto_request_mode;
   logic                               stall_ctl;
   logic                               ovr_err_flag;
   logic                               stall_flag;
   logic                               nak_timeout_flag;
   logic                               data_error_flag;
   logic [1:0]                         fail_count;
   logic                               nak_seen;
   logic [usb_rx_ep_pkg::FRAMES_W-1:0] nak_frames;
   logic [5:0]                         tx_target_and_protocol;
   logic [7:0]                         tx_poll_interval;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire        wr_maxp   = reg_write && reg_addr == usb_rx_ep_pkg::OFF_MAXP;
   wire        wr_csr    = reg_write && reg_addr == usb_rx_ep_pkg::OFF_CSR;
   wire        wr_tx_target_and_protocol = reg_write && reg_addr == usb_rx_ep_pkg::OFF_TX_TYPE;
   wire        wr_txintv = reg_write && reg_addr == usb_rx_ep_pkg::OFF_TX_INTV;

   wire        iso_ep    = host_mode ? rx_protocol == usb_rx_ep_pkg::PROTO_ISO
                                     : iso_or_auto_request_mode;
   wire        auto_request_mode = host_mode && iso_or_auto_request_mode;
   wire        send_stall_a      = !host_mode && stall_ctl;
   wire        request_in_transfer = host_mode && stall_ctl;
   wire        bulk_int_host = host_mode && (rx_protocol == usb_rx_ep_pkg::PROTO_BULK
                                          || rx_protocol == usb_rx_ep_pkg::PROTO_INTR);
   wire        bulk_host = host_mode && rx_protocol == usb_rx_ep_pkg::PROTO_BULK;

   // Buffer depth; software keeps the payload within capacity
   wire [CW-1:0] max_x2  = {1'b0, max_payload_bytes, 1'b0};
   wire [CW-1:0] max_ext = {2'h0, max_payload_bytes};
   wire          double_ok = max_x2 <= CW'(BUF_BYTES);
   wire [1:0]    depth     = double_ok ? 2'h2 : 2'h1;
   wire          is_full   = pkt_count >= depth;
   wire          is_ready  = pkt_count != 2'h0;

   // Packet arrival and drop
   wire        store       = link_event.pkt_done && !is_full;
   wire        drop        = link_event.pkt_done && is_full;
   wire        overrun_set = drop && !host_mode && iso_ep;

   // Unloading and popping the front packet
   wire        take     = unload_byte && is_ready && front_left != '0;
   wire        sw_clear = wr_csr && !reg_wdata[usb_rx_ep_pkg::CSR_READY] && is_ready;
   wire        flush    = wr_csr && reg_wdata[usb_rx_ep_pkg::CSR_FLUSH] && is_ready;
   wire        auto_pop = auto_clear_mode && take && front_left == CW'(1)
                          && front_size == max_ext;
   wire        pop      = sw_clear || flush || auto_pop;
   wire [1:0]  next_pkt_count = 2'(pkt_count + {1'b0, store} - {1'b0, pop});
   wire        ready_rise = !is_ready && next_pkt_count != 2'h0;
   wire        ready_fall = is_ready && next_pkt_count == 2'h0;

   // Handshake events; the packet engine withholds data while stalling
   wire        stall_out = send_stall_a && !iso_ep && link_event.out_token;
   wire        stall_rx_set = host_mode && link_event.stall_in;
   wire        attempt_fail = bulk_int_host && link_event.attempt_failed;
   wire        error_set = attempt_fail
                           && fail_count == usb_rx_ep_pkg::ERR_ATTEMPTS - 2'h1;

   // NAK limit shares the transmit interval decode
   wire [usb_rx_ep_pkg::FRAMES_W-1:0] nak_limit =
      interval_frames(usb_rx_ep_pkg::PROTO_BULK, rx_nak_limit);
   wire        nak_run = bulk_host && nak_seen && nak_limit != '0 && !nak_timeout_flag;
   wire [usb_rx_ep_pkg::FRAMES_W-1:0] nak_next = 16'(nak_frames + 16'h0001);
   wire        nak_set = nak_run && link_event.frame_tick && nak_next >= nak_limit;
   wire        csr_clr_nak = wr_csr && host_mode
                             && !reg_wdata[usb_rx_ep_pkg::CSR_DERR_NAK];

   // Sticky flags: a set in the clearing cycle wins
   wire        next_ovr_err = overrun_set || error_set
      || (ovr_err_flag && !(wr_csr && !reg_wdata[usb_rx_ep_pkg::CSR_OVR_ERR]));
   wire        next_stall_flag = stall_out || stall_rx_set
      || (stall_flag && !(wr_csr && !reg_wdata[usb_rx_ep_pkg::CSR_STALL_EVT]));
   wire        next_nak_to = nak_set || (nak_timeout_flag && !csr_clr_nak);
   wire        derr_set = store && link_event.pkt_bad && iso_ep && !host_mode;
   wire        next_derr = derr_set || (data_error_flag && !(wr_csr && !host_mode
      && !reg_wdata[usb_rx_ep_pkg::CSR_DERR_NAK]));

   // Send-stall or request bit
   wire        req_write = wr_csr && reg_wdata[usb_rx_ep_pkg::CSR_STALL_CTL];
   wire        next_stall_ctl =
      !host_mode ? (wr_csr ? reg_wdata[usb_rx_ep_pkg::CSR_STALL_CTL] : stall_ctl)
                 : ((stall_ctl || req_write || (auto_request_mode && ready_fall))
                    && !ready_rise);

   // Byte count follows stores, unloads and pops
   wire [CW-1:0] byte_sub = pop ? front_left : {{(CW-1){1'b0}}, take};
   wire [CW-1:0] byte_add = store ? link_event.pkt_bytes : '0;
   wire [CW-1:0] next_byte_count = CW'(byte_count - byte_sub + byte_add);

   ////////////////////////////////////////////////////////////////////////
   // Two-slot packet queue
   logic [CW-1:0] next_front_size;
   logic [CW-1:0] next_front_left;
   logic          next_front_err;
   logic [CW-1:0] next_back_size;
   logic          next_back_err;
   logic [1:0]    slot;

   always_comb begin
      next_front_size = front_size;
      next_front_left = front_left;
      next_front_err  = front_err;
      next_back_size  = back_size;
      next_back_err   = back_err;
      slot            = pop ? 2'(pkt_count - 2'h1) : pkt_count;
      if (take && !pop)
         next_front_left = CW'(front_left - CW'(1));
      if (pop) begin
         next_front_size = back_size;
         next_front_left = back_size;
         next_front_err  = back_err;
      end
      if (store && slot == 2'h0) begin
         next_front_size = link_event.pkt_bytes;
         next_front_left = link_event.pkt_bytes;
         next_front_err  = link_event.pkt_bad;
      end else if (store) begin
         next_back_size  = link_event.pkt_bytes;
         next_back_err   = link_event.pkt_bad;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status view; bit 3 carries data error or NAK timeout by mode
   logic [usb_rx_ep_pkg::DATA_W-1:0] csr_view;

   always_comb begin
      csr_view = '0;
      csr_view[usb_rx_ep_pkg::CSR_READY]     = is_ready;
      csr_view[usb_rx_ep_pkg::CSR_FULL]      = is_full;
      csr_view[usb_rx_ep_pkg::CSR_OVR_ERR]   = ovr_err_flag;
      csr_view[usb_rx_ep_pkg::CSR_DERR_NAK]  = host_mode
         ? nak_timeout_flag || (front_err && iso_ep && is_ready)
         : data_error_flag;
      csr_view[usb_rx_ep_pkg::CSR_STALL_CTL] = stall_ctl;
      csr_view[usb_rx_ep_pkg::CSR_STALL_EVT] = stall_flag;
      csr_view[usb_rx_ep_pkg::CSR_ISO_AREQ]  = iso_or_auto_request_mode;
      csr_view[usb_rx_ep_pkg::CSR_AUTO_CLR]  = auto_clear_mode;
   end

   wire [usb_rx_ep_pkg::DATA_W-1:0] rd_mux =
      reg_addr == usb_rx_ep_pkg::OFF_MAXP    ? {5'h00, max_payload_bytes} :
      reg_addr == usb_rx_ep_pkg::OFF_CSR     ? csr_view :
      reg_addr == usb_rx_ep_pkg::OFF_COUNT   ? {3'h0, byte_count} :
      reg_addr == usb_rx_ep_pkg::OFF_TX_TYPE ? {10'h000, tx_target_and_protocol} :
      reg_addr == usb_rx_ep_pkg::OFF_TX_INTV ? {8'h00, tx_poll_interval} :
                                               16'h0000;

   wire [1:0]  tx_proto_field =
      tx_target_and_protocol[usb_rx_ep_pkg::TX_PROTO_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         max_payload_bytes <= usb_rx_ep_pkg::MAXP_RESET;
         pkt_count         <= 2'h0;
         front_size        <= usb_rx_ep_pkg::COUNT_RESET;
         front_left        <= usb_rx_ep_pkg::COUNT_RESET;
         front_err         <= 1'b0;
         back_size         <= usb_rx_ep_pkg::COUNT_RESET;
         back_err          <= 1'b0;
         byte_count        <= usb_rx_ep_pkg::COUNT_RESET;
      end else begin
         if (wr_maxp)
            max_payload_bytes <= reg_wdata[usb_rx_ep_pkg::MAXP_W-1:0];
         pkt_count  <= next_pkt_count;
         front_size <= next_front_size;
         front_left <= next_front_left;
         front_err  <= next_front_err;
         back_size  <= next_back_size;
         back_err   <= next_back_err;
         byte_count <= next_byte_count;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         auto_clear_mode  <= 1'b0;
         iso_or_auto_request_mode   <= 1'b0;
         stall_ctl        <= 1'b0;
         ovr_err_flag     <= 1'b0;
         stall_flag       <= 1'b0;
         nak_timeout_flag <= 1'b0;
         data_error_flag  <= 1'b0;
      end else begin
         if (wr_csr) begin
            auto_clear_mode <= reg_wdata[usb_rx_ep_pkg::CSR_AUTO_CLR];
            iso_or_auto_request_mode  <= reg_wdata[usb_rx_ep_pkg::CSR_ISO_AREQ];
         end
         stall_ctl        <= next_stall_ctl;
         ovr_err_flag     <= next_ovr_err;
         stall_flag       <= next_stall_flag;
         nak_timeout_flag <= next_nak_to;
         data_error_flag  <= next_derr;
      end
   end

   // Failure and NAK counters restart on any delivered packet
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fail_count <= 2'h0;
         nak_seen   <= 1'b0;
         nak_frames <= '0;
      end else begin
         if (link_event.pkt_done || error_set)
            fail_count <= 2'h0;
         else if (attempt_fail)
            fail_count <= 2'(fail_count + 2'h1);
         if (link_event.pkt_done || link_event.stall_in || csr_clr_nak) begin
            nak_seen   <= 1'b0;
            nak_frames <= '0;
         end else begin
            if (bulk_host && link_event.nak)
               nak_seen <= 1'b1;
            if (nak_run && link_event.frame_tick)
               nak_frames <= nak_next;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_target_and_protocol <= usb_rx_ep_pkg::TX_TYPE_RESET;
         tx_poll_interval       <= usb_rx_ep_pkg::TX_INTV_RESET;
      end else begin
         if (wr_tx_target_and_protocol)
            tx_target_and_protocol <= reg_wdata[5:0];
         if (wr_txintv)
            tx_poll_interval <= reg_wdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all registered; status outputs lag the view by one cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reg_rdata          <= '0;
         packet_ready       <= 1'b0;
         buffer_full        <= 1'b0;
         in_request         <= 1'b0;
         endpoint_halted    <= 1'b0;
         stall_handshake    <= 1'b0;
         data_toggle        <= 1'b0;
         endpoint_irq       <= 1'b0;
         tx_target_endpoint <= 4'h0;
         tx_protocol        <= usb_rx_ep_pkg::PROTO_RSVD;
         tx_interval_frames <= '0;
      end else begin
         reg_rdata       <= reg_read ? rd_mux : '0;
         packet_ready    <= is_ready;
         buffer_full     <= is_full;
         // A halted endpoint issues no requests until the flag is cleared
         in_request      <= request_in_transfer && !nak_timeout_flag;
         endpoint_halted <= nak_timeout_flag;
         stall_handshake <= stall_out;
         if (wr_csr && reg_wdata[usb_rx_ep_pkg::CSR_CLR_TOG])
            data_toggle <= 1'b0;
         else if (link_event.toggle_flip)
            data_toggle <= !data_toggle;
         endpoint_irq    <= (irq_enable && (ready_rise || stall_rx_set))
                            || error_set;
         tx_target_endpoint <=
            tx_target_and_protocol[usb_rx_ep_pkg::TX_EP_LSB +: usb_rx_ep_pkg::TX_EP_W];
         tx_protocol        <= tx_proto_field;
         tx_interval_frames <= interval_frames(tx_proto_field, tx_poll_interval);
      end
   end

endmodule : usb_rx_endpoint_control

// File: verification/usb_link_partner.sv
// Far-side link model: bench commands become one-cycle event pulses
// Assumes the bench holds each command for one clock
`timescale 1ns/1ps
module usb_link_partner (
   input  wire logic                     clk,
   input  wire logic [2:0]               cmd,
   input  wire logic [12:0]              bytes,
   output usb_rx_ep_pkg::link_event_type link_event
);
   // Byte field is scrambled outside a packet, never left stale
   always_ff @(posedge clk) begin
      link_event <= '0;
      link_event.pkt_done <= cmd == 3'h1 || cmd == 3'h7;
      link_event.pkt_bytes <= (cmd == 3'h1 || cmd == 3'h7) ? bytes : ~bytes;
      link_event.pkt_bad <= cmd == 3'h7;
      link_event.out_token <= cmd == 3'h2;
      link_event.attempt_failed <= cmd == 3'h3;
      link_event.stall_in <= cmd == 3'h4;
      link_event.nak <= cmd == 3'h5;
      link_event.frame_tick <= cmd == 3'h5;
      link_event.toggle_flip <= cmd == 3'h6;
   end
endmodule : usb_link_partner

// File: verification/usb_rx_endpoint_control_checker.sv
// Port-level checks of the receive endpoint control
// Assumes binding onto the design top module
`timescale 1ns/1ps
module usb_rx_endpoint_control_checker (
   input wire logic        clk, rstn, reg_write, reg_read, host_mode,
   input wire logic [2:0]  reg_addr,
   input wire logic [15:0] reg_wdata, reg_rdata,
   input wire usb_rx_ep_pkg::link_event_type link_event,
   input wire logic        packet_ready, buffer_full, in_request, endpoint_halted,
   input wire logic        stall_handshake, data_toggle, endpoint_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_reset_quiet: assert property (disable iff (1'b0) !rstn |=>
      !packet_ready && !in_request && !endpoint_irq && reg_rdata == 16'h0000)
      else $error("outputs active after reset");
   chk_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   chk_ready_cause: assert property ($rose(packet_ready) |-> $past(link_event.pkt_done, 2))
      else $error("ready rose without a packet");
   chk_irq_cause: assert property (endpoint_irq |->
      $past(link_event.pkt_done || link_event.stall_in || link_event.attempt_failed))
      else $error("interrupt without a cause");
   chk_full_ready: assert property (buffer_full |-> packet_ready)
      else $error("full while nothing ready");
   chk_stall_cause: assert property (stall_handshake |->
      $past(link_event.out_token && !host_mode))
      else $error("stall without an OUT token");
   chk_halt_blocks: assert property (endpoint_halted |-> !in_request)
      else $error("request while halted");
   chk_toggle_zero: assert property (reg_write && reg_addr == usb_rx_ep_pkg::OFF_CSR &&
      reg_wdata[usb_rx_ep_pkg::CSR_CLR_TOG] |-> ##[1:2] !data_toggle)
      else $error("toggle not cleared");
   chk_request_drop: assert property ($rose(packet_ready) && host_mode |-> !in_request)
      else $error("request kept after packet");
endmodule : usb_rx_endpoint_control_checker
bind usb_rx_endpoint_control usb_rx_endpoint_control_checker u_chk (.clk, .rstn, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .host_mode, .link_event, .packet_ready,
   .buffer_full, .in_request, .endpoint_halted, .stall_handshake, .data_toggle, .endpoint_irq);

// File: verification/usb_rx_endpoint_control_tb.sv
// Bench: register tasks and link scenarios for the receive endpoint
// Assumes the link partner model and the bound checker
`timescale 1ns/1ps
module usb_rx_endpoint_control_tb;
   localparam logic [2:0] CSR = usb_rx_ep_pkg::OFF_CSR;
   logic        clk, rstn, reg_write, reg_read, host_mode, packet_ready, buffer_full;
   logic        in_request, stall_handshake, endpoint_halted, data_toggle, unload;
   logic [2:0]  reg_addr, cmd;
   logic [15:0] reg_wdata, reg_rdata, tx_interval_frames;
   logic [12:0] bytes;
   logic [3:0]  tx_target_endpoint;
   logic [1:0]  tx_protocol;
   usb_rx_ep_pkg::link_event_type link_event;
   int          errors, compares;
   usb_link_partner u_link (.clk, .cmd, .bytes, .link_event);
   usb_rx_endpoint_control u_dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .host_mode, .rx_protocol(2'h2), .rx_nak_limit(8'h02), .irq_enable(1'b1),
      .link_event, .unload_byte(unload), .packet_ready, .buffer_full, .in_request,
      .endpoint_halted, .stall_handshake, .data_toggle, .endpoint_irq(),
      .tx_target_endpoint, .tx_protocol, .tx_interval_frames);
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [2:0] a, logic [15:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(logic [2:0] a, logic [15:0] e);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
   endtask : rd
   task automatic pulse(logic [2:0] c, logic [12:0] b);
      @(posedge clk);
      cmd   <= c;
      bytes <= b;
      @(posedge clk);
      cmd <= 3'h0;
   endtask : pulse
   task automatic tx(logic [7:0] t, logic [7:0] n, logic [15:0] f);
      wr(usb_rx_ep_pkg::OFF_TX_TYPE, {8'h00, t});
      wr(usb_rx_ep_pkg::OFF_TX_INTV, {8'h00, n});
      rd(usb_rx_ep_pkg::OFF_TX_TYPE, {8'h00, t});
      chk("frames", f, tx_interval_frames);
      chk("target", {12'h000, t[3:0]}, {12'h000, tx_target_endpoint});
      chk("proto", {14'h0000, t[5:4]}, {14'h0000, tx_protocol});
   endtask : tx
   task automatic final_report();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Tests need under two hundred cycles; generous margin
   initial begin
      repeat (4000) @(posedge clk);
      errors++;
      final_report();
   end
   initial begin
      {rstn, reg_write, reg_read, host_mode, unload, reg_addr, cmd} = 11'h000;
      reg_wdata = 16'h0000;
      bytes = 13'h0000;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(i[2:0], 16'h0000);
      wr(3'h0, 16'hFFFF);
      rd(3'h0, 16'h07FF);
      wr(3'h0, 16'h0008);
      $display("test registers done");
      pulse(3'h1, 13'h0008);
      pulse(3'h1, 13'h0008);
      rd(CSR, 16'h0003);
      rd(3'h2, 16'h0010);
      chk("full", 16'h0001, {15'h0000, buffer_full});
      wr(CSR, 16'h4001);
      pulse(3'h1, 13'h0008);
      rd(CSR, 16'h4007);
      wr(CSR, 16'h4015);
      rd(3'h2, 16'h0008);
      rd(CSR, 16'h4005);
      wr(CSR, 16'h0011);
      rd(CSR, 16'h0000);
      wr(CSR, 16'h4001);
      pulse(3'h7, 13'h0008);
      rd(CSR, 16'h4009);
      wr(CSR, 16'h0000);
      wr(CSR, 16'h8001);
      pulse(3'h1, 13'h0008);
      unload <= 1'b1;
      repeat (9) @(posedge clk);
      unload <= 1'b0;
      rd(CSR, 16'h8000);
      $display("test buffer done");
      pulse(3'h6, 13'h0000);
      @(posedge clk);
      #1 chk("toggle", 16'h0001, {15'h0000, data_toggle});
      wr(CSR, 16'h00A1);
      pulse(3'h2, 13'h0000);
      @(posedge clk);
      #1 chk("stall", 16'h0001, {15'h0000, stall_handshake});
      chk("toggle", 16'h0000, {15'h0000, data_toggle});
      rd(CSR, 16'h0060);
      wr(CSR, 16'h0001);
      rd(CSR, 16'h0000);
      $display("test stall done");
      @(posedge clk);
      host_mode <= 1'b1;
      wr(CSR, 16'h0021);
      repeat (2) @(posedge clk);
      #1 chk("request", 16'h0001, {15'h0000, in_request});
      pulse(3'h1, 13'h0004);
      repeat (2) @(posedge clk);
      #1 chk("request", 16'h0000, {15'h0000, in_request});
      chk("ready", 16'h0001, {15'h0000, packet_ready});
      repeat (3) pulse(3'h3, 13'h0000);
      rd(CSR, 16'h0005);
      wr(CSR, 16'h0025);
      repeat (3) pulse(3'h5, 13'h0000);
      rd(CSR, 16'h002D);
      chk("halted", 16'h0001, {15'h0000, endpoint_halted});
      chk("request", 16'h0000, {15'h0000, in_request});
      pulse(3'h4, 13'h0000);
      rd(CSR, 16'h006D);
      wr(CSR, 16'h0000);
      rd(CSR, 16'h0020);
      chk("halted", 16'h0000, {15'h0000, endpoint_halted});
      wr(CSR, 16'h4001);
      pulse(3'h1, 13'h0004);
      wr(CSR, 16'h4000);
      rd(CSR, 16'h4020);
      $display("test host done");
      tx(8'h1A, 8'h03, 16'h0004);
      tx(8'h3B, 8'h05, 16'h0005);
      tx(8'h2C, 8'h03, 16'h0004);
      $display("test transmit done");
      final_report();
   end
endmodule : usb_rx_endpoint_control_tb
